/* File: design/ncd_dp_map.vh */
// Opcode, reset, compare and BCD adjust constants for the nibble datapath.
`ifndef NCD_DP_MAP_VH
`define NCD_DP_MAP_VH
`define NCD_OP_CLEAR_WORK_REG 8'hC0
`define NCD_OP_CARRY_CLEAR 8'hE1
`define NCD_OP_CARRY_SET 8'hF1
`define NCD_OP_ONES_COMPLEMENT 8'hEB
`define NCD_OP_INC_WORK 8'h0E
`define NCD_OP_DEC_WORK 8'h0F
`define NCD_OP_ROTATE_LEFT 8'h01
`define NCD_OP_COPY_TO_EXT 8'h03
`define NCD_OP_SWAP_WITH_EXT 8'h0D
`define NCD_OP_MEM_PLUS_ONE 8'h2E
`define NCD_OP_MEM_MINUS_ONE 8'h2F
`define NCD_OP_ADD 8'h60
`define NCD_OP_ADD_CARRY 8'h20
`define NCD_OP_BCD_ADJ_ADD 8'hE6
`define NCD_OP_BCD_ADJ_SUB 8'hEA
`define NCD_OP_XOR_MEM 8'hF5
`define NCD_OP_AND_MEM 8'hE7
`define NCD_OP_OR_MEM 8'hE5
`define NCD_OP_COMPARE_MEM 8'hFB
`define NCD_OP_COMPARE_IMM 8'h2C
`define NCD_OP_PTR_LOW_CMP 8'h3C
`define NCD_OP_STORE 8'h02
`define NCD_OP_LOAD 8'h21
`define NCD_OP_SWAP_MEM 8'hA0
`define NCD_OP_SWAP_STEP_UP 8'hFE
`define NCD_OP_SWAP_STEP_DOWN 8'hFF
`define NCD_OP_ROM_TABLE_READ 8'h63
`define NCD_OPH_LOAD_IMM 4'hC
`define NCD_OPM_BIT_SET 6'h02
`define NCD_OPM_BIT_CLEAR 6'h0A
`define NCD_OPM_SWAP_XOR_HIGH 5'h14
`define NCD_CMP_IMM_MASK 4'hF
`define NCD_CMP_IMM_LOW 4'h0
`define NCD_BCD_ADD_VAL 4'h6
`define NCD_BCD_SUB_VAL 4'hA
`define NCD_RST_NIBBLE 4'h0
`define NCD_RST_FLAG 1'b0
`endif

/* File: design/ncd_datapath.v */
// Accumulator, memory and compare datapath of a 4-bit controller core.
`timescale 1ns/100ps
`include "ncd_dp_map.vh"
// How it works
// - Complement work_reg, zero_bit from result
// - Rotate work_reg left through carry_bit
// - Copy work_reg into E, flags kept
// - Swap work_reg with E, flags kept
// - Set chosen bit of addressed nibble
// - Clear chosen bit of addressed nibble
// - Add memory to work_reg, both flags
// - Add memory plus carry, update carry
// - BCD adjust adds six or ten
// - XOR memory into work_reg, zero only
// - AND or OR memory, zero only
// - Memory compare sets carry and zero
// - Immediate compare, two bytes, same flags
// - Pointer-low compare, zero flag only
// - Load opcode immediate, update zero
// - Store work_reg to memory, flags kept
// - Load memory nibble, update zero
// - Swap memory, XOR pointer_high, zero
// - Swap memory, zero from old pointer_high
// - Swap memory, increment pointer_low, zero
// - Swap memory, decrement pointer_low, zero
// - Table read loads work_reg and E
module ncd_datapath #(
	parameter RAM_DEPTH = 256,
	parameter ROM_AW = 12
) (
	input wire core_clk,
	input wire rst,
	input wire op_valid,
	input wire [7:0] op_code,
	input wire [ROM_AW-1:0] pc_value,
	input wire [3:0] pointer_high_in,
	input wire [3:0] pointer_low_in,
	input wire pointer_load,
	input wire [7:0] rom_data,
	output reg op_ready,
	output reg [3:0] work_reg,
	output reg [3:0] ext_reg,
	output reg carry_bit,
	output reg zero_bit,
	output reg [3:0] pointer_high,
	output reg [3:0] pointer_low,
	output reg [ROM_AW-1:0] rom_addr,
	output reg rom_rd
);
	localparam ST_IDLE = 2'b00;
	localparam ST_SECOND = 2'b01;
	localparam ST_ROM = 2'b10;
	reg [1:0] state_r;
	reg [7:0] held_op_r;
	reg [3:0] mem_r [0:RAM_DEPTH-1];
	reg [3:0] ac_nxt;
	reg [3:0] e_nxt;
	reg c_nxt;
	reg z_nxt;
	reg [3:0] ph_nxt;
	reg [3:0] pl_nxt;
	reg [3:0] m_nxt;
	reg m_we;
	reg [1:0] state_nxt;
	reg [7:0] held_nxt;
	reg [4:0] sum5;
	reg [3:0] pl_t;
	wire [7:0] mem_addr = {pointer_high, pointer_low};
	wire [3:0] mem_q = mem_r[mem_addr];
	wire [3:0] bit_mask;
	genvar gi;
	// One decoder line per nibble bit picks the bit that set or clear touches.
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit_sel
			localparam [1:0] SEL = gi;
			assign bit_mask[gi] = (op_code[1:0] == SEL);
		end
	endgenerate
	// Compare encoding: carry when memory is not above work_reg, zero on equality.
	function [1:0] cmp_flags;
		input [3:0] lhs;
		input [3:0] ac;
		begin
			cmp_flags = {(lhs <= ac), (lhs == ac)};
		end
	endfunction
	always @* begin
		ac_nxt = work_reg;
		e_nxt = ext_reg;
		c_nxt = carry_bit;
		z_nxt = zero_bit;
		ph_nxt = pointer_high;
		pl_nxt = pointer_low;
		m_nxt = mem_q;
		m_we = 1'b0;
		state_nxt = state_r;
		held_nxt = held_op_r;
		sum5 = 5'h00;
		pl_t = 4'h0;
		case (state_r)
		ST_IDLE: begin
			if (op_valid) begin
				if (op_code[7:4] == `NCD_OPH_LOAD_IMM) begin
					ac_nxt = op_code[3:0];
					z_nxt = (ac_nxt == 4'h0);
				end else if (op_code[7:2] == `NCD_OPM_BIT_SET) begin
					m_nxt = mem_q | bit_mask;
					m_we = 1'b1;
				end else if (op_code[7:2] == `NCD_OPM_BIT_CLEAR) begin
					m_nxt = mem_q & ~bit_mask;
					m_we = 1'b1;
				end else if (op_code[7:3] == `NCD_OPM_SWAP_XOR_HIGH) begin
					// The plain swap shares this pattern with a zero field.
					ac_nxt = mem_q;
					m_nxt = work_reg;
					m_we = 1'b1;
					ph_nxt = pointer_high ^ {1'b0, op_code[2:0]};
					z_nxt = (ph_nxt == 4'h0);
					state_nxt = ST_SECOND;
				end else begin
					case (op_code)
					`NCD_OP_CLEAR_WORK_REG: begin
						ac_nxt = 4'h0;
						z_nxt = 1'b1;
					end
					`NCD_OP_CARRY_CLEAR: begin
						c_nxt = 1'b0;
					end
					`NCD_OP_CARRY_SET: begin
						c_nxt = 1'b1;
					end
					`NCD_OP_ONES_COMPLEMENT: begin
						ac_nxt = ~work_reg;
						z_nxt = (ac_nxt == 4'h0);
					end
					// Carry is the fifth bit, so it reads as borrow on a decrement.
					`NCD_OP_INC_WORK, `NCD_OP_DEC_WORK: begin
						sum5 = op_code[0] ? ({1'b0, work_reg} - 5'h01)
							: ({1'b0, work_reg} + 5'h01);
						ac_nxt = sum5[3:0];
						c_nxt = sum5[4];
						z_nxt = (sum5[3:0] == 4'h0);
					end
					`NCD_OP_MEM_PLUS_ONE, `NCD_OP_MEM_MINUS_ONE: begin
						sum5 = op_code[0] ? ({1'b0, mem_q} - 5'h01)
							: ({1'b0, mem_q} + 5'h01);
						m_nxt = sum5[3:0];
						m_we = 1'b1;
						c_nxt = sum5[4];
						z_nxt = (sum5[3:0] == 4'h0);
					end
					`NCD_OP_ROTATE_LEFT: begin
						ac_nxt = {work_reg[2:0], carry_bit};
						c_nxt = work_reg[3];
						z_nxt = (ac_nxt == 4'h0);
					end
					`NCD_OP_COPY_TO_EXT: begin
						e_nxt = work_reg;
					end
					`NCD_OP_SWAP_WITH_EXT: begin
						ac_nxt = ext_reg;
						e_nxt = work_reg;
					end
					`NCD_OP_ADD: begin
						sum5 = {1'b0, work_reg} + {1'b0, mem_q};
						ac_nxt = sum5[3:0];
						c_nxt = sum5[4];
						z_nxt = (sum5[3:0] == 4'h0);
					end
					// Add with carry leaves the zero flag as it was.
					`NCD_OP_ADD_CARRY: begin
						sum5 = {1'b0, work_reg} + {1'b0, mem_q} + {4'h0, carry_bit};
						ac_nxt = sum5[3:0];
						c_nxt = sum5[4];
					end
					`NCD_OP_BCD_ADJ_ADD: begin
						ac_nxt = work_reg + `NCD_BCD_ADD_VAL;
						z_nxt = (ac_nxt == 4'h0);
					end
					// The subtract adjust touches no flag; software tests carry first.
					`NCD_OP_BCD_ADJ_SUB: begin
						ac_nxt = work_reg + `NCD_BCD_SUB_VAL;
					end
					`NCD_OP_XOR_MEM: begin
						ac_nxt = work_reg ^ mem_q;
						z_nxt = (ac_nxt == 4'h0);
					end
					`NCD_OP_AND_MEM: begin
						ac_nxt = work_reg & mem_q;
						z_nxt = (ac_nxt == 4'h0);
					end
					`NCD_OP_OR_MEM: begin
						ac_nxt = work_reg | mem_q;
						z_nxt = (ac_nxt == 4'h0);
					end
					`NCD_OP_COMPARE_MEM: begin
						{c_nxt, z_nxt} = cmp_flags(mem_q, work_reg);
					end
					// Immediate compares wait for their second byte before any flag moves.
					`NCD_OP_COMPARE_IMM, `NCD_OP_PTR_LOW_CMP: begin
						held_nxt = op_code;
						state_nxt = ST_SECOND;
					end
					`NCD_OP_STORE: begin
						m_nxt = work_reg;
						m_we = 1'b1;
					end
					`NCD_OP_LOAD: begin
						ac_nxt = mem_q;
						z_nxt = (ac_nxt == 4'h0);
					end
					`NCD_OP_SWAP_STEP_UP, `NCD_OP_SWAP_STEP_DOWN: begin
						ac_nxt = mem_q;
						m_nxt = work_reg;
						m_we = 1'b1;
						pl_t = op_code[0] ? (pointer_low - 4'h1)
							: (pointer_low + 4'h1);
						pl_nxt = pl_t;
						z_nxt = (pl_t == 4'h0);
						state_nxt = ST_SECOND;
					end
					`NCD_OP_ROM_TABLE_READ: begin
						state_nxt = ST_SECOND;
					end
					default: ;
					endcase
					held_nxt = op_code;
				end
				if (op_code[7:3] == `NCD_OPM_SWAP_XOR_HIGH)
					held_nxt = op_code;
			end
		end
		ST_SECOND: begin
			// Second cycle: immediate byte for compares; table read raises the ROM strobe for the third cycle.
			state_nxt = ST_IDLE;
			if (held_op_r == `NCD_OP_COMPARE_IMM && op_valid) begin
				{c_nxt, z_nxt} = cmp_flags(op_code[3:0], work_reg);
			end else if (held_op_r == `NCD_OP_PTR_LOW_CMP && op_valid) begin
				z_nxt = (pointer_low == op_code[3:0]);
			end else if (held_op_r == `NCD_OP_ROM_TABLE_READ) begin
				state_nxt = ST_ROM;
			end
		end
		ST_ROM: begin
			ac_nxt = rom_data[3:0];
			e_nxt = rom_data[7:4];
			state_nxt = ST_IDLE;
		end
		default: state_nxt = ST_IDLE;
		endcase
		// A pointer load only lands between instructions, so it never races a swap.
		if (pointer_load && state_r == ST_IDLE && !op_valid) begin
			ph_nxt = pointer_high_in;
			pl_nxt = pointer_low_in;
		end
	end
	// RAM has no reset; software must write a nibble before reading it.
	// Leaving it unreset keeps the array free of a wide reset tree.
	always @(posedge core_clk) begin
		if (m_we)
			mem_r[mem_addr] <= m_nxt;
	end
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			held_op_r <= 8'h00;
			work_reg <= `NCD_RST_NIBBLE;
			ext_reg <= `NCD_RST_NIBBLE;
			carry_bit <= `NCD_RST_FLAG;
			zero_bit <= `NCD_RST_FLAG;
			pointer_high <= `NCD_RST_NIBBLE;
			pointer_low <= `NCD_RST_NIBBLE;
			op_ready <= 1'b0;
		end else begin
			state_r <= state_nxt;
			held_op_r <= held_nxt;
			work_reg <= ac_nxt;
			ext_reg <= e_nxt;
			carry_bit <= c_nxt;
			zero_bit <= z_nxt;
			pointer_high <= ph_nxt;
			pointer_low <= pl_nxt;
			op_ready <= (state_nxt == ST_IDLE);
		end
	end
	// The ROM strobe and address are registered so the fetch sees a clean pulse.
	// The address holds after the strobe drops, which lets slow ROM models settle.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rom_addr <= {ROM_AW{1'b0}};
			rom_rd <= 1'b0;
		end else begin
			rom_rd <= (state_nxt == ST_ROM);
			if (state_nxt == ST_ROM)
				rom_addr <= {pc_value[ROM_AW-1:8], ext_reg, work_reg};
		end
	end
endmodule // ncd_datapath

/* File: bench/ncd_dp_chk_assertions.sv */
// Port checker for the nibble datapath.
`timescale 1ns/100ps
`include "ncd_dp_map.vh"
module ncd_dp_chk #(parameter ROM_AW = 12) (
	input wire core_clk,
	input wire rst,
	input wire op_valid,
	input wire [7:0] op_code,
	input wire [ROM_AW-1:0] pc_value,
	input wire op_ready,
	input wire [3:0] work_reg,
	input wire [3:0] ext_reg,
	input wire carry_bit,
	input wire zero_bit,
	input wire [3:0] pointer_low,
	input wire [ROM_AW-1:0] rom_addr,
	input wire rom_rd
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire tk = op_valid && op_ready;
	sequence s_imm;
		tk && op_code == `NCD_OP_COMPARE_IMM ##1 op_valid;
	endsequence
	sequence s_tab;
		tk && op_code == `NCD_OP_ROM_TABLE_READ;
	endsequence
	AST_CMA: assert property (tk && op_code == `NCD_OP_ONES_COMPLEMENT |=>
		work_reg == ~$past(work_reg) && zero_bit == (work_reg == 4'h0)) else $error("cma");
	AST_RAL: assert property (tk && op_code == `NCD_OP_ROTATE_LEFT |=>
		work_reg == {$past(work_reg[2:0]), $past(carry_bit)} && carry_bit == $past(work_reg[3]))
		else $error("rotate");
	AST_TAE: assert property (tk && op_code == `NCD_OP_COPY_TO_EXT |=>
		ext_reg == $past(work_reg) && $stable(carry_bit) && $stable(zero_bit)) else $error("copy");
	AST_XAE: assert property (tk && op_code == `NCD_OP_SWAP_WITH_EXT |=>
		work_reg == $past(ext_reg) && ext_reg == $past(work_reg)) else $error("swap e");
	AST_DAA: assert property (tk && op_code == `NCD_OP_BCD_ADJ_ADD |=>
		work_reg == $past(work_reg) + 4'h6) else $error("adjust");
	AST_CI: assert property (s_imm |=> carry_bit == ($past(op_code[3:0]) <= work_reg) &&
		zero_bit == ($past(op_code[3:0]) == work_reg)) else $error("compare imm");
	AST_LI: assert property (tk && op_code[7:4] == `NCD_OPH_LOAD_IMM |=>
		work_reg == $past(op_code[3:0])) else $error("load imm");
	AST_XI: assert property (tk && op_code == `NCD_OP_SWAP_STEP_UP |=>
		pointer_low == $past(pointer_low) + 4'h1 && zero_bit == (pointer_low == 4'h0))
		else $error("step up");
	AST_STC: assert property (tk && op_code == `NCD_OP_CARRY_SET |=> carry_bit)
		else $error("carry set");
	AST_TAB: assert property (s_tab |-> ##[1:3] (rom_rd &&
		rom_addr == {pc_value[ROM_AW-1:8], ext_reg, work_reg})) else $error("table addr");
endmodule // ncd_dp_chk
bind ncd_datapath ncd_dp_chk #(.ROM_AW(ROM_AW)) u_ncd_dp_chk (.core_clk, .rst, .op_valid,
	.op_code, .pc_value, .op_ready, .work_reg, .ext_reg, .carry_bit, .zero_bit, .pointer_low,
	.rom_addr, .rom_rd);

/* File: bench/ncd_datapath_tb.sv */
// Directed bench for the nibble datapath.
`timescale 1ns/100ps
module ncd_datapath_tb;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg op_valid = 1'b0;
	reg pointer_load = 1'b0;
	reg [7:0] op_code = 8'h00;
	reg [7:0] rom_data = 8'h9E;
	reg [11:0] pc_value = 12'hA5C;
	reg [3:0] pointer_high_in = 4'h0;
	reg [3:0] pointer_low_in = 4'h0;
	wire op_ready, carry_bit, zero_bit, rom_rd;
	wire [3:0] work_reg, ext_reg, pointer_high, pointer_low;
	wire [11:0] rom_addr;
	wire [5:0] st = {work_reg, carry_bit, zero_bit};
	integer num_errors = 0;
	integer cmp_count = 0;
	ncd_datapath u_ncd_datapath (.core_clk, .rst, .op_valid, .op_code, .pc_value,
		.pointer_high_in, .pointer_low_in, .pointer_load, .rom_data, .op_ready, .work_reg,
		.ext_reg, .carry_bit, .zero_bit, .pointer_high, .pointer_low, .rom_addr, .rom_rd);
	initial forever #2 core_clk = ~core_clk;
	task tally_and_finish;
	begin
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end
	endtask
	task chk(input [5:0] s, input [5:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			num_errors = num_errors + 1;
			$display("wrong value t=%0t saw %h exp %h", $time, s, e);
		end
	end
	endtask
	// A two-byte op keeps op_valid high so the immediate byte follows without a gap.
	task go(input [7:0] c, input h);
	integer n;
	begin
		n = 0;
		while (op_ready !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1 n = n + 1;
		end
		if (n == 20) begin
			num_errors = num_errors + 1;
			tally_and_finish;
		end else begin
			op_valid = 1'b1;
			op_code = c;
			@(posedge core_clk);
			#1 op_valid = h;
			// A gap cycle keeps op_valid from falling and rising in one step.
			if (!h) begin
				@(posedge core_clk);
				#1;
			end
		end
	end
	endtask
	task go2(input [7:0] a, input [7:0] b);
	begin
		go(a, 1'b1);
		op_code = b;
		@(posedge core_clk);
		#1 op_valid = 1'b0;
		@(posedge core_clk);
		#1;
	end
	endtask
	task ptr(input [3:0] hi, input [3:0] lo);
	begin
		@(posedge core_clk);
		#1 pointer_load = 1'b1;
		pointer_high_in = hi;
		pointer_low_in = lo;
		@(posedge core_clk);
		#1 pointer_load = 1'b0;
	end
	endtask
	task t_mem;
	begin
		ptr(4'h2, 4'h7);
		go(8'hC5, 0); go(`NCD_OP_STORE, 0); go(8'hC9, 0); go(`NCD_OP_LOAD, 0);
		chk(st, {4'h5, 2'b00});
		go(8'hC9, 0); go(`NCD_OP_ADD, 0); chk(st, {4'hE, 2'b00});
		go(8'hCB, 0); go(`NCD_OP_ADD, 0); chk(st, {4'h0, 2'b11});
		go(8'hCB, 0); go(`NCD_OP_ADD_CARRY, 0); chk(st, {4'h1, 2'b10});
		go(8'hC6, 0); go(`NCD_OP_XOR_MEM, 0); chk(st, {4'h3, 2'b10});
		go(8'hC6, 0); go(`NCD_OP_AND_MEM, 0); chk(st, {4'h4, 2'b10});
		go(8'hC6, 0); go(`NCD_OP_OR_MEM, 0); chk(st, {4'h7, 2'b10});
		go(8'h09, 0); go(`NCD_OP_LOAD, 0); chk(st, {4'h7, 2'b10});
		go(8'h28, 0); go(`NCD_OP_LOAD, 0); chk(st, {4'h6, 2'b10});
		go(`NCD_OP_MEM_PLUS_ONE, 0); go(`NCD_OP_LOAD, 0); chk(st, {4'h7, 2'b00});
		go(8'hC7, 0); go(`NCD_OP_COMPARE_MEM, 0); chk(st, {4'h7, 2'b11});
		go(8'hC9, 0); go(`NCD_OP_COMPARE_MEM, 0); chk(st, {4'h9, 2'b10});
		go(8'hC3, 0); go(`NCD_OP_COMPARE_MEM, 0); chk(st, {4'h3, 2'b00});
	end
	endtask
	task t_acc;
	begin
		go(8'hCF, 0); go(`NCD_OP_ONES_COMPLEMENT, 0); chk(st, {4'h0, 2'b01});
		go(`NCD_OP_CARRY_SET, 0); go(8'hC8, 0); go(`NCD_OP_ROTATE_LEFT, 0);
		chk(st, {4'h1, 2'b10});
		go(8'hC3, 0); go(`NCD_OP_COPY_TO_EXT, 0); chk({ext_reg, 2'b10}, st);
		go(8'hCC, 0); go(`NCD_OP_SWAP_WITH_EXT, 0); chk({ext_reg, 2'b10}, 6'h32);
		go(8'hC4, 0); go(`NCD_OP_BCD_ADJ_SUB, 0); chk({work_reg, 2'b00}, 6'h38);
		go(`NCD_OP_CARRY_CLEAR, 0); go(`NCD_OP_CLEAR_WORK_REG, 0); chk(st, 6'h01);
		go(`NCD_OP_DEC_WORK, 0); chk(st, {4'hF, 2'b10});
	end
	endtask
	task t_cmp;
	begin
		go(8'hC5, 0); go2(`NCD_OP_COMPARE_IMM, 8'h05); chk(st, {4'h5, 2'b11});
		go2(`NCD_OP_COMPARE_IMM, 8'h07); chk(st, {4'h5, 2'b00});
		go(`NCD_OP_CARRY_SET, 0); ptr(4'h2, 4'h3);
		go2(`NCD_OP_PTR_LOW_CMP, 8'h03); chk(st, {4'h5, 2'b11});
		go2(`NCD_OP_PTR_LOW_CMP, 8'h04); chk(st, {4'h5, 2'b10});
	end
	endtask
	task t_swap;
	begin
		ptr(4'h2, 4'hF); go(8'hC8, 0); go(`NCD_OP_STORE, 0); go(8'hC1, 0);
		go(`NCD_OP_SWAP_STEP_UP, 0); chk({work_reg, zero_bit, 1'b0}, 6'h22);
		go(`NCD_OP_SWAP_STEP_DOWN, 0); chk({pointer_low, zero_bit, 1'b0}, 6'h3C);
		go(8'hA5, 0); chk({work_reg, 2'b00}, 6'h04);
		chk({pointer_high, zero_bit, 1'b0}, 6'h1C);
		ptr(4'h0, 4'hF); go(8'hC9, 0); go(`NCD_OP_STORE, 0); go(8'hC2, 0);
		go(`NCD_OP_SWAP_MEM, 0); chk({work_reg, zero_bit, 1'b0}, 6'h26);
	end
	endtask
	task t_rom;
	begin
		go(8'hC3, 0); go(`NCD_OP_COPY_TO_EXT, 0); go(8'hC7, 0); go(`NCD_OP_ROM_TABLE_READ, 0);
		go(8'hE1, 0); chk({ext_reg, work_reg[3:2]}, 6'h27);
	end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1 rst = 1'b0;
		t_mem;
		t_acc;
		t_cmp;
		t_swap;
		t_rom;
		tally_and_finish;
	end
endmodule // ncd_datapath_tb
